// ---- verif/port_pin_checker_assertions.sv ----
`timescale 1ns/1ps
module port_pin_checker (
    // Clock, resets, strobes
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       pin_reset,
    input wire logic       data_rd,
    input wire logic       bit_op_req,
    input wire logic       debug_en_clr,
    // Watched outputs and pads
    input wire logic [7:0] data_rdata,
    input wire logic       data_rvalid,
    input wire logic       nmi_req,
    input wire logic       debug_enable_bit,
    input wire logic       debug_mode,
    input wire logic       debug_pull_down,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] alt_in
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic en_seen_ff;
    // Enable value last seen outside reset
    always_ff @(posedge core_clk) if (reset_n) en_seen_ff <= debug_enable_bit;
    a_alt_gated: assert property ((alt_in & ~$past(pin_in, 3)) == 8'h00)
        else $error("alt input high with pin low");
    a_read_answer: assert property (data_rd || bit_op_req |=> data_rvalid)
        else $error("read not answered");
    a_rdata_hold: assert property (!data_rvalid |-> $stable(data_rdata))
        else $error("read data moved");
    a_dbg_init: assert property ($rose(reset_n) && $past(pin_reset) |->
        debug_enable_bit && debug_pull_down && !debug_mode)
        else $error("debug start-up wrong");
    a_dbg_keep: assert property ($rose(reset_n) && !$past(pin_reset) |->
        debug_enable_bit == en_seen_ff)
        else $error("debug enable lost");
    a_dbg_clear: assert property (debug_en_clr |=>
        !debug_enable_bit && !debug_pull_down && !debug_mode)
        else $error("debug clear failed");
    a_dbg_pad_off: assert property (debug_enable_bit && $past(debug_enable_bit) |->
        !pin_oe[port_pin_pkg::DBG_PIN_BIT])
        else $error("debug pad driven");
    a_nmi_cause: assert property (nmi_req |-> $past(alt_in[port_pin_pkg::INT_PIN_BIT]) !=
        $past(alt_in[port_pin_pkg::INT_PIN_BIT], 2))
        else $error("nmi without edge");
endmodule

// ---- verif/port_pins_model.sv ----
`timescale 1ns/1ps
module port_pins_model (
    // Pad controls
    input  wire logic       core_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic       pull_down,
    // Board drive
    input  wire logic [7:0] ext_level,
    input  wire logic [7:0] ext_drive,
    // Pad levels
    output logic      [7:0] pin_in
);
    logic [7:0] float_ff = 8'h55;
    // Released pads wander every cycle
    always @(posedge core_clk) float_ff <= ~float_ff;
    // Port drive wins, then board, then pull-down or wander
    always_comb begin
        pin_in = float_ff;
        pin_in[port_pin_pkg::DBG_PIN_BIT] = float_ff[port_pin_pkg::DBG_PIN_BIT] & ~pull_down;
        pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_drive & ext_level) | (~ext_drive & pin_in)));
    end
endmodule

// ---- verif/tb_port_pin_altfunc_control.sv ----
`timescale 1ns/1ps
module tb_port_pin_altfunc_control;
    logic                    core_clk, reset_n, pin_reset, cfg_we, data_wr, data_rd, bit_op_req;
    logic                    debug_en_clr, data_rvalid, nmi_req, debug_enable_bit, debug_mode;
    logic                    debug_pull_down;
    logic [7:0]              data_wdata, data_rdata, pin_in, pin_out, pin_oe, alt_in;
    logic [7:0]              ext_level, ext_drive;
    logic [2:0]              bit_idx;
    port_pin_pkg::port_cfg_t cfg_in;
    port_pin_pkg::bit_op_t   bit_op;
    port_pin_pkg::edge_sel_t nmi_edge_sel;
    int                      errors, n_tests, nmi_base;
    int                      nmi_cnt = 0;
    logic [7:0]              ops_old [4] = '{8'hfe, 8'hff, 8'hfe, 8'hff};
    logic [7:0]              nmi_exp [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
    port_pin_altfunc_control i_dut (.core_clk, .reset_n, .pin_reset, .cfg_in, .cfg_we, .data_wr,
        .data_wdata, .data_rd, .bit_op_req, .bit_op, .bit_idx, .data_rdata, .data_rvalid,
        .nmi_edge_sel, .nmi_req, .debug_en_clr, .debug_enable_bit, .debug_mode,
        .debug_pull_down, .pin_in, .pin_out, .pin_oe, .alt_in);
    port_pins_model i_pins (.core_clk, .pin_out, .pin_oe, .pull_down(debug_pull_down),
        .ext_level, .ext_drive, .pin_in);
    // Clock and interrupt counter
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (nmi_req === 1'h1) nmi_cnt++;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic strobe(ref logic s);
        @(negedge core_clk) s = 1'h1;
        @(negedge core_clk) s = 1'h0;
    endtask
    task automatic rd(input logic [7:0] exp);
        strobe(data_rd);
        chk(8'(data_rvalid), 8'h01);
        chk(data_rdata, exp);
    endtask
    task automatic cfg(input logic [7:0] d, input logic [7:0] f, input logic [7:0] o);
        cfg_in = '{d, f, o};
        strobe(cfg_we);
        repeat (4) @(negedge core_clk);
    endtask
    task automatic rst(input logic pr);
        @(negedge core_clk) pin_reset = pr;
        reset_n = 1'h0;
        repeat (6) @(negedge core_clk);
        reset_n = 1'h1;
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {cfg_we, data_wr, data_rd, bit_op_req, debug_en_clr} = 5'h00;
        {data_wdata, bit_idx, ext_drive} = {8'h00, 3'h0, 8'hff};
        cfg_in = '{8'hff, 8'h00, 8'h00};
        bit_op = port_pin_pkg::BIT_SET;
        nmi_edge_sel = port_pin_pkg::EDGE_NONE;
        ext_level = 8'h85;
        {errors, n_tests} = '0;
        // Pin reset held for six clocks from the start
        {reset_n, pin_reset} = 2'h1;
        repeat (6) @(negedge core_clk);
        reset_n = 1'h1;
        chk(8'({debug_enable_bit, debug_pull_down, debug_mode}), 8'h06);
        // Let the pin synchroniser fill
        @(negedge core_clk);
        rd(8'h85);
        strobe(debug_en_clr);
        chk(8'({debug_enable_bit, debug_pull_down}), 8'h00);
        ext_level = 8'hff;
        cfg(8'hfe, 8'h00, 8'h00);
        data_wdata = 8'h00;
        strobe(data_wr);
        for (int i = 0; i < 4; i++) begin
            bit_op = port_pin_pkg::bit_op_t'(i);
            strobe(bit_op_req);
            chk(data_rdata, ops_old[i]);
        end
        rd(8'hff);
        chk(pin_oe, 8'h01);
        cfg(8'h00, 8'h00, 8'h00);
        chk(pin_out, 8'hff);
        data_wdata = 8'h3c;
        strobe(data_wr);
        rd(8'h3c);
        cfg(8'h00, 8'h00, 8'hff);
        chk(pin_out, 8'h00);
        chk(pin_oe, 8'hc3);
        cfg(8'hff, 8'h00, 8'hff);
        chk(pin_oe, 8'h00);
        cfg(8'h00, 8'h00, 8'h00);
        chk(pin_out, 8'h3c);
        bit_idx = 3'h6;
        bit_op = port_pin_pkg::BIT_SET;
        strobe(bit_op_req);
        chk(data_rdata, 8'h3c);
        rd(8'h7c);
        cfg(8'hff, 8'h00, 8'h00);
        chk(alt_in, 8'h00);
        for (int e = 0; e < 4; e++) begin
            nmi_edge_sel = port_pin_pkg::edge_sel_t'(e);
            nmi_base = nmi_cnt;
            cfg(8'hff, 8'h04, 8'h00);
            chk(alt_in, 8'h04);
            cfg(8'hff, 8'h00, 8'h00);
            chk(8'(nmi_cnt - nmi_base), nmi_exp[e]);
        end
        // open-drain and choices settle before the select bit
        nmi_edge_sel = port_pin_pkg::EDGE_NONE;
        nmi_base = nmi_cnt;
        // select set before the interrupt input is used
        cfg(8'hff, 8'h04, 8'h00);
        // valid edge chosen only after the switch
        nmi_edge_sel = port_pin_pkg::EDGE_BOTH;
        repeat (4) @(negedge core_clk);
        // no-edge chosen before returning to port use
        nmi_edge_sel = port_pin_pkg::EDGE_NONE;
        // interrupt use stopped before the select clears
        cfg(8'hff, 8'h00, 8'h00);
        chk(8'(nmi_cnt - nmi_base), 8'h00);
        rst(1'h0);
        chk(8'({debug_enable_bit, debug_pull_down}), 8'h00);
        rst(1'h1);
        chk(8'({debug_enable_bit, debug_pull_down}), 8'h03);
        repeat (5) @(negedge core_clk);
        chk(8'(debug_mode), 8'h01);
        strobe(debug_en_clr);
        chk(8'(debug_mode), 8'h00);
        tally_and_finish();
    end
    // Watchdog
    initial begin
        #500000;
        errors++;
        tally_and_finish();
    end
endmodule
bind port_pin_altfunc_control port_pin_checker i_chk (.core_clk, .reset_n, .pin_reset,
    .data_rd, .bit_op_req, .debug_en_clr, .data_rdata, .data_rvalid, .nmi_req,
    .debug_enable_bit, .debug_mode, .debug_pull_down, .pin_in, .pin_oe, .alt_in);

// ---- verilog/edge_detector.sv ----
`timescale 1ns/1ps
module edge_detector (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // Gated input and edge choice
    input  wire logic                  level_in,
    input  wire port_pin_pkg::edge_sel_t edge_sel,
    // Event pulse
    output logic                       edge_pulse
);
    logic prev_ff;
    logic nxt_prev;
    logic pulse_ff;
    logic nxt_pulse;

    always_comb begin
        nxt_prev = level_in;
        unique case (edge_sel)
            port_pin_pkg::EDGE_NONE: nxt_pulse = 1'b0;
            port_pin_pkg::EDGE_RISE: nxt_pulse = level_in & ~prev_ff;
            port_pin_pkg::EDGE_FALL: nxt_pulse = ~level_in & prev_ff;
            port_pin_pkg::EDGE_BOTH: nxt_pulse = level_in ^ prev_ff;
        endcase
    end

    // Register history and pulse
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prev_ff  <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            prev_ff  <= nxt_prev;
            pulse_ff <= nxt_pulse;
        end
    end

    assign edge_pulse = pulse_ff;
endmodule

// ---- verilog/port_pin_altfunc_control.sv ----
`timescale 1ns/1ps
module port_pin_altfunc_control (
    // Clock and resets
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    input  wire logic                    pin_reset,
    // Port configuration
    input  wire port_pin_pkg::port_cfg_t cfg_in,
    input  wire logic                    cfg_we,
    // Port data register access
    input  wire logic                    data_wr,
    input  wire logic [7:0]              data_wdata,
    input  wire logic                    data_rd,
    input  wire logic                    bit_op_req,
    input  wire port_pin_pkg::bit_op_t   bit_op,
    input  wire logic [2:0]              bit_idx,
    output logic [7:0]                   data_rdata,
    output logic                         data_rvalid,
    // Interrupt edge choice and event
    input  wire port_pin_pkg::edge_sel_t nmi_edge_sel,
    output logic                         nmi_req,
    // Debug mode control
    input  wire logic                    debug_en_clr,
    output logic                         debug_enable_bit,
    output logic                         debug_mode,
    output logic                         debug_pull_down,
    // Pins
    input  wire logic [7:0]              pin_in,
    output logic [7:0]                   pin_out,
    output logic [7:0]                   pin_oe,
    // Alternate function inputs
    output logic [7:0]                   alt_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic [7:0]              sync1_ff;
    logic [7:0]              sync2_ff;
    // Port data and configuration
    logic [7:0]              latch_ff;
    logic [7:0]              nxt_latch;
    port_pin_pkg::port_cfg_t cfg_ff;
    port_pin_pkg::port_cfg_t nxt_cfg;
    logic [7:0]              rdata_ff;
    logic [7:0]              nxt_rdata;
    logic                    rvalid_ff;
    logic                    nxt_rvalid;
    // Debug control
    logic                    dbg_en_ff;
    logic                    nxt_dbg_en;
    logic                    dbg_mode_ff;
    logic                    nxt_dbg_mode;
    logic                    pd_ff;
    logic                    nxt_pd;
    // Pad drive and peripheral inputs
    logic [7:0]              alt_ff;
    logic [7:0]              nxt_alt;
    logic [7:0]              out_ff;
    logic [7:0]              nxt_out;
    logic [7:0]              oe_ff;
    logic [7:0]              nxt_oe;
    // Read view and modified byte
    logic [7:0]              rd_view;
    logic [7:0]              modified;

    // Readback per bit by direction
    function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] lat,
                                             input logic [7:0] pins);
        port_view = (dir & pins) | (~dir & lat);
    endfunction

    // Only the second stage feeds logic; the first may be metastable
    // Two-stage synchroniser on pins
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read view
    assign rd_view = port_view(cfg_ff.direction, latch_ff, sync2_ff);

    always_comb begin
        modified = rd_view;
        unique case (bit_op)
            port_pin_pkg::BIT_SET: modified[bit_idx] = 1'b1;
            port_pin_pkg::BIT_CLR: modified[bit_idx] = 1'b0;
            port_pin_pkg::BIT_NOT: modified[bit_idx] = ~rd_view[bit_idx];
            port_pin_pkg::BIT_TST: modified = rd_view;
        endcase
    end

    // Latch, config and read data next values
    always_comb begin
        nxt_latch  = latch_ff;
        nxt_cfg    = cfg_ff;
        nxt_rdata  = rdata_ff;
        nxt_rvalid = 1'b0;
        if (cfg_we) begin
            nxt_cfg = cfg_in;
        end
        // A set, clear or invert bit operation takes the cycle when it meets a plain write; a test does not
        // latch on writes and on set, clear or invert bit ops
        if (bit_op_req && bit_op != port_pin_pkg::BIT_TST) begin
            nxt_latch = modified;
        end else if (data_wr) begin
            nxt_latch = data_wdata;
        end
        if (data_rd || bit_op_req) begin
            nxt_rdata  = rd_view;
            nxt_rvalid = 1'b1;
        end
    end

    // Register port state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            latch_ff  <= port_pin_pkg::LATCH_RST;
            cfg_ff    <= '{port_pin_pkg::DIR_RST, port_pin_pkg::FSEL_RST, port_pin_pkg::OD_RST};
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            latch_ff  <= nxt_latch;
            cfg_ff    <= nxt_cfg;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive and gated peripheral inputs
    always_comb begin
        nxt_alt = sync2_ff & cfg_ff.func_sel;
        nxt_out = 8'h00;
        nxt_oe  = 8'h00;
        for (int i = 0; i < port_pin_pkg::PORT_W; i++) begin
            if (!cfg_ff.func_sel[i] && !cfg_ff.direction[i]) begin
                // A zero pulls the pad low, a one releases it
                // open drain on outputs
                if (cfg_ff.open_drain[i]) begin
                    nxt_out[i] = 1'b0;
                    nxt_oe[i]  = ~latch_ff[i];
                end else begin
                    nxt_out[i] = latch_ff[i];
                    nxt_oe[i]  = 1'b1;
                end
            end
        end
        // Debug reset pin never driven while in debug use
        if (dbg_en_ff) begin
            nxt_oe[port_pin_pkg::DBG_PIN_BIT] = 1'b0;
        end
    end

    // Register pad drive
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            alt_ff <= 8'h00;
            out_ff <= 8'h00;
            oe_ff  <= 8'h00;
        end else begin
            alt_ff <= nxt_alt;
            out_ff <= nxt_out;
            oe_ff  <= nxt_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug control next values
    always_comb begin
        nxt_dbg_en   = dbg_en_ff;
        nxt_dbg_mode = dbg_mode_ff;
        nxt_pd       = pd_ff;
        // Clearing the enable wins over a pin-high debug entry
        if (debug_en_clr) begin
            nxt_dbg_en   = 1'b0;
            nxt_dbg_mode = 1'b0;
            nxt_pd       = 1'b0;
        end else if (dbg_en_ff && sync2_ff[port_pin_pkg::DBG_PIN_BIT]) begin
            // A high pin before the clear enters debug mode unguarded
            // high enters debug; no guard
            nxt_dbg_mode = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n && pin_reset) begin
            dbg_en_ff   <= port_pin_pkg::DEBUG_EN_RST;
            dbg_mode_ff <= 1'b0;
            pd_ff       <= 1'b1;
        end else if (reset_n) begin
            dbg_en_ff   <= nxt_dbg_en;
            dbg_mode_ff <= nxt_dbg_mode;
            pd_ff       <= nxt_pd;
        end
    end

    // Gated input is registered and starts low, so no edge follows reset
    // interrupt edge on gated input
    edge_detector u_nmi_edge (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .level_in   (alt_ff[port_pin_pkg::INT_PIN_BIT]),
        .edge_sel   (nmi_edge_sel),
        .edge_pulse (nmi_req)
    );

    // Outputs straight from their registers
    assign data_rdata       = rdata_ff;
    assign data_rvalid      = rvalid_ff;
    assign debug_enable_bit = dbg_en_ff;
    assign debug_mode       = dbg_mode_ff;
    assign debug_pull_down  = pd_ff;
    assign pin_out          = out_ff;
    assign pin_oe           = oe_ff;
    assign alt_in           = alt_ff;
endmodule

// ---- verilog/port_pin_pkg.sv ----
package port_pin_pkg;
    localparam int unsigned PORT_W = 8;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] FSEL_RST = 8'h00;
    localparam logic [7:0] OD_RST = 8'h00;
    localparam logic DEBUG_EN_RST = 1'b1;
    localparam int unsigned INT_PIN_BIT = 2;
    localparam int unsigned DBG_PIN_BIT = 5;
    // Bit access opcodes
    typedef enum logic [1:0] {BIT_SET, BIT_CLR, BIT_NOT, BIT_TST} bit_op_t;
    // Per-bit configuration carried as one group
    typedef struct packed {
        logic [7:0] direction;
        logic [7:0] func_sel;
        logic [7:0] open_drain;
    } port_cfg_t;
    // Edge selection for interrupt detector
    typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_t;
endpackage
